/* File: stm_pkg.sv */
package stm_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] STM_CTRL_OFS      = 8'h00;
  localparam logic [7:0] STM_STATUS_OFS    = 8'h04;
  localparam logic [7:0] STM_IRQ_MASK_OFS  = 8'h08;
  localparam logic [7:0] STM_TQ_OVER_OFS   = 8'h0c;
  localparam logic [7:0] STM_TQ_UNDER_OFS  = 8'h10;
  localparam logic [7:0] STM_VE_OVER_OFS   = 8'h14;
  localparam logic [7:0] STM_VE_UNDER_OFS  = 8'h18;
  localparam logic [7:0] STM_V_OVER_OFS    = 8'h1c;
  localparam logic [7:0] STM_V_UNDER_OFS   = 8'h20;
  localparam logic [7:0] STM_VGAIN_OFS     = 8'h24;
  localparam logic [7:0] STM_SGAIN_OFS     = 8'h28;
  localparam logic [7:0] STM_SETTLE_OFS    = 8'h2c;
  localparam logic [7:0] STM_INDEX_OFS     = 8'h30;
  localparam logic [7:0] STM_TORQUE_OFS    = 8'h34;
  localparam logic [7:0] STM_VEL_OFS       = 8'h38;
  localparam logic [7:0] STM_VCMD_OFS      = 8'h3c;
  localparam logic [7:0] STM_VERR_OFS      = 8'h40;
  localparam logic [7:0] STM_FLAGS_OFS     = 8'h44;
  localparam logic [7:0] STM_DUMP_OFS      = 8'h48;

  // Flag and status bit positions
  localparam int STM_TQ_OVER_BIT  = 0;
  localparam int STM_TQ_UNDER_BIT = 1;
  localparam int STM_VE_OVER_BIT  = 2;
  localparam int STM_VE_UNDER_BIT = 3;
  localparam int STM_V_OVER_BIT   = 4;
  localparam int STM_V_UNDER_BIT  = 5;
  localparam int STM_DONE_BIT     = 6;
  localparam int STM_NUM_EVT      = 7;

  // Control register bit positions
  localparam int STM_CTRL_NEWHW_BIT = 0;
  localparam int STM_CTRL_DUMP_BIT  = 1;

  // Thresholds: torque in 0.01 %, velocity in 0.001 rev/s
  localparam logic [15:0] STM_TQ_MAX   = 16'h2710;
  localparam logic [15:0] STM_VEL_MAX  = 16'h2710;
  localparam logic [15:0] STM_THR_RST  = 16'h0000;

  // Gain in 0.01 units: 0.10 .. 255.00, defaults 0.50 and 1.50
  localparam logic [15:0] STM_VG_MIN     = 16'h000a;
  localparam logic [15:0] STM_VG_MAX     = 16'h639c;
  localparam logic [15:0] STM_VG_OLD_RST = 16'h0032;
  localparam logic [15:0] STM_VG_NEW_RST = 16'h0096;

  // Time base 0.1 ms, maximum 2146410442 ticks
  localparam int          STM_CLK_HZ       = 50000000;
  localparam int          STM_TICK_US      = 100;
  localparam int          STM_TICK_CYC     = STM_CLK_HZ / 1000000
                                             * STM_TICK_US;
  localparam logic [31:0] STM_TIME_MAX     = 32'h7fef9fca;

  // Number of dumpable parameter words
  localparam int STM_DUMP_WORDS = 9;

  // Measurement state
  typedef enum logic [0:0] {STM_IDLE, STM_MOVING} stm_meas_t;

  // Servo sample bundle from the loop
  typedef struct packed {
    logic signed [15:0] torque;
    logic signed [15:0] vel;
    logic signed [15:0] vcmd;
    logic signed [15:0] verr;
  } stm_sample_t;

  // Programmable thresholds
  typedef struct packed {
    logic [15:0] tq_over;
    logic [15:0] tq_under;
    logic [15:0] ve_over;
    logic [15:0] ve_under;
    logic [15:0] v_over;
    logic [15:0] v_under;
  } stm_thr_t;

endpackage

/* File: stm_monitor.sv */
`timescale 1ns/100ps
module stm_monitor
  import stm_pkg::*;
#(
  parameter int TICK_CYC = STM_TICK_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire stm_sample_t sample_in,
  input  wire logic        sample_strobe_in,
  input  wire logic        move_start_in,
  input  wire logic        move_done_in,
  output logic             torque_over_flag_out,
  output logic             torque_under_flag_out,
  output logic             velocity_err_over_flag_out,
  output logic             velocity_err_under_flag_out,
  output logic             velocity_over_flag_out,
  output logic             velocity_under_flag_out,
  output logic      [15:0] velocity_prop_gain_out,
  output logic             irq_out
);

  // The tick counter is 16 bits wide, so longer ticks cannot be served
  if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_tick_chk
    $error("TICK_CYC must lie in 1..65536");
  end

  // Whole module state in one record
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic                  newhw;          // Later hardware version
    stm_thr_t              thr;            // Comparator thresholds
    logic [15:0]           vgain;          // Velocity prop gain
    logic [15:0]           sgain;          // Tuned servo gain
    stm_sample_t           smp;            // Latched sample
    logic [5:0]            flags;          // Comparator outputs
    logic [STM_NUM_EVT-1:0] status;        // Sticky events
    logic [STM_NUM_EVT-1:0] mask;          // Interrupt enables
    logic                  irq;
    stm_meas_t             meas;
    logic [15:0]           tick_cnt;       // Cycles within a tick
    logic [31:0]           settle_time;    // Running settle time
    logic [31:0]           index_time;     // Running index time
    logic [31:0]           settle_last;    // Settle time of last move
    logic [31:0]           index_last;     // Index time of last move
    logic [3:0]            dump_idx;       // Dump cursor
  } stm_state_t;

  stm_state_t s_q;
  stm_state_t s_d;

  // Magnitude of a signed sample, saturating at most-negative
  function automatic logic [15:0] stm_abs(input logic signed [15:0] v);
    if (v[15]) begin
      stm_abs = (v == 16'sh8000) ? 16'h7fff : 16'(-v);
    end else begin
      stm_abs = v;
    end
  endfunction

  // Clamp a written threshold into its range
  function automatic logic [15:0] stm_clamp(input logic [15:0] v,
                                            input logic [15:0] hi);
    stm_clamp = (v > hi) ? hi : v;
  endfunction

  // Saturating time increment
  function automatic logic [31:0] stm_inc(input logic [31:0] t);
    stm_inc = (t >= STM_TIME_MAX) ? STM_TIME_MAX : t + 32'h1;
  endfunction

  // Dump word list; home offset and multi-line setting live
  // outside this block and are never listed
  function automatic logic [31:0] stm_dump_word(input stm_state_t s,
                                                input logic [3:0] i);
    case (i)
      4'h0:    stm_dump_word = {16'h0, s.thr.tq_over};
      4'h1:    stm_dump_word = {16'h0, s.thr.tq_under};
      4'h2:    stm_dump_word = {16'h0, s.thr.ve_over};
      4'h3:    stm_dump_word = {16'h0, s.thr.ve_under};
      4'h4:    stm_dump_word = {16'h0, s.thr.v_over};
      4'h5:    stm_dump_word = {16'h0, s.thr.v_under};
      4'h6:    stm_dump_word = {16'h0, s.vgain};
      4'h7:    stm_dump_word = {16'h0, s.sgain};
      4'h8:    stm_dump_word = {31'h0, s.newhw};
      default: stm_dump_word = 32'h0;
    endcase
  endfunction

  logic                   wr_req;
  logic                   rd_req;
  logic [31:0]            wmask;
  logic [31:0]            wval;
  logic [STM_NUM_EVT-1:0] evt;
  logic [15:0]            new_gain;
  logic [15:0]            a_vel;
  logic [15:0]            a_err;
  logic                   tick;
  logic [31:0]            dump_w;         // Dump word under the cursor

  // Next-state logic for bus, comparators, timers and gains
  always_comb begin
    s_d      = s_q;
    evt      = '0;
    wr_req   = wb_cyc_in && wb_stb_in && wb_we_in && !s_q.ack;
    rd_req   = wb_cyc_in && wb_stb_in && !wb_we_in && !s_q.ack;
    wmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    wval     = wb_dat_in & wmask;
    new_gain = s_q.vgain;
    a_vel    = stm_abs(sample_in.vel);
    a_err    = stm_abs(sample_in.verr);
    tick     = 1'b0;
    dump_w   = stm_dump_word(s_q, s_q.dump_idx);

    // Ack one cycle after the strobe, drop the next cycle
    s_d.ack = (wb_cyc_in && wb_stb_in && !s_q.ack);

    // Compare fresh sample against thresholds in the same cycle
    if (sample_strobe_in) begin
      s_d.smp = sample_in;
      s_d.flags[STM_TQ_OVER_BIT] =
        (sample_in.torque >= $signed({1'b0, s_q.thr.tq_over[14:0]}));
      s_d.flags[STM_TQ_UNDER_BIT] =
        (sample_in.torque <= $signed({1'b0, s_q.thr.tq_under[14:0]}));
      s_d.flags[STM_VE_OVER_BIT]  = (a_err >= s_q.thr.ve_over);
      s_d.flags[STM_VE_UNDER_BIT] = (a_err <= s_q.thr.ve_under);
      s_d.flags[STM_V_OVER_BIT]   = (a_vel >= s_q.thr.v_over);
      s_d.flags[STM_V_UNDER_BIT]  = (a_vel <= s_q.thr.v_under);
      // Rising flag edges are events
      evt[5:0] = s_d.flags & ~s_q.flags;
    end

    // Tick generator for 0.1 ms time base
    if (s_q.tick_cnt >= 16'(TICK_CYC - 1)) begin
      s_d.tick_cnt = 16'h0;
      tick         = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h1;
    end

    // Move timing; completion both latches and clears
    case (s_q.meas)
      STM_IDLE: begin
        if (move_start_in) begin
          s_d.meas        = STM_MOVING;
          s_d.settle_time = 32'h0;
          s_d.index_time  = 32'h0;
          s_d.tick_cnt    = 16'h0;
        end
      end
      STM_MOVING: begin
        if (move_done_in) begin
          s_d.meas        = STM_IDLE;
          s_d.settle_last = s_q.settle_time;
          s_d.index_last  = s_q.index_time;
          s_d.settle_time = 32'h0;
          s_d.index_time  = 32'h0;
          evt[STM_DONE_BIT] = 1'b1;
        end else if (tick) begin
          s_d.settle_time = stm_inc(s_q.settle_time);
          s_d.index_time  = stm_inc(s_q.index_time);
        end
      end
      default: s_d.meas = STM_IDLE;
    endcase

    // Register writes; dumped values written back restore state
    if (wr_req) begin
      case (wb_adr_in)
        STM_CTRL_OFS: begin
          if (wb_sel_in[0]) begin
            s_d.newhw = wb_dat_in[STM_CTRL_NEWHW_BIT];
            if (wb_dat_in[STM_CTRL_DUMP_BIT]) begin
              s_d.dump_idx = 4'h0;
            end
          end
        end
        STM_STATUS_OFS:
          s_d.status = s_q.status & ~wval[STM_NUM_EVT-1:0];
        STM_IRQ_MASK_OFS:
          s_d.mask = (s_q.mask & ~wmask[STM_NUM_EVT-1:0])
                     | wval[STM_NUM_EVT-1:0];
        STM_TQ_OVER_OFS:
          s_d.thr.tq_over  = stm_clamp(wval[15:0], STM_TQ_MAX);
        STM_TQ_UNDER_OFS:
          s_d.thr.tq_under = stm_clamp(wval[15:0], STM_TQ_MAX);
        STM_VE_OVER_OFS:
          s_d.thr.ve_over  = stm_clamp(wval[15:0], STM_VEL_MAX);
        STM_VE_UNDER_OFS:
          s_d.thr.ve_under = stm_clamp(wval[15:0], STM_VEL_MAX);
        STM_V_OVER_OFS:
          s_d.thr.v_over   = stm_clamp(wval[15:0], STM_VEL_MAX);
        STM_V_UNDER_OFS:
          s_d.thr.v_under  = stm_clamp(wval[15:0], STM_VEL_MAX);
        STM_VGAIN_OFS: begin
          // Out-of-range gains are ignored, keeping the old value
          if (wval[15:0] >= STM_VG_MIN && wval[15:0] <= STM_VG_MAX) begin
            new_gain = wval[15:0];
          end
          if (new_gain != s_q.vgain) begin
            s_d.vgain = new_gain;
            s_d.sgain = 16'h0;
          end
        end
        STM_SGAIN_OFS:
          s_d.sgain = wval[15:0];
        default: ;
      endcase
    end

    // Read mux; unmapped addresses read zero
    if (rd_req) begin
      case (wb_adr_in)
        STM_CTRL_OFS:     s_d.rdata = {31'h0, s_q.newhw};
        STM_STATUS_OFS:   s_d.rdata = 32'(s_q.status);
        STM_IRQ_MASK_OFS: s_d.rdata = 32'(s_q.mask);
        STM_TQ_OVER_OFS:  s_d.rdata = {16'h0, s_q.thr.tq_over};
        STM_TQ_UNDER_OFS: s_d.rdata = {16'h0, s_q.thr.tq_under};
        STM_VE_OVER_OFS:  s_d.rdata = {16'h0, s_q.thr.ve_over};
        STM_VE_UNDER_OFS: s_d.rdata = {16'h0, s_q.thr.ve_under};
        STM_V_OVER_OFS:   s_d.rdata = {16'h0, s_q.thr.v_over};
        STM_V_UNDER_OFS:  s_d.rdata = {16'h0, s_q.thr.v_under};
        STM_VGAIN_OFS:    s_d.rdata = {16'h0, s_q.vgain};
        STM_SGAIN_OFS:    s_d.rdata = {16'h0, s_q.sgain};
        STM_SETTLE_OFS:   s_d.rdata = s_q.settle_last;
        STM_INDEX_OFS:    s_d.rdata = s_q.index_last;
        STM_TORQUE_OFS:   s_d.rdata = 32'(s_q.smp.torque);
        STM_VEL_OFS:      s_d.rdata = 32'(s_q.smp.vel);
        STM_VCMD_OFS:     s_d.rdata = 32'(s_q.smp.vcmd);
        STM_VERR_OFS:     s_d.rdata = 32'(s_q.smp.verr);
        STM_FLAGS_OFS:    s_d.rdata = {26'h0, s_q.flags};
        STM_DUMP_OFS: begin
          // Index in top nibble, value below; cursor then advances, stopping at 9
          s_d.rdata = {s_q.dump_idx, 4'h0, dump_w[23:0]};
          if (s_q.dump_idx < 4'(STM_DUMP_WORDS)) begin
            s_d.dump_idx = s_q.dump_idx + 4'h1;
          end
        end
        default:          s_d.rdata = 32'h0;
      endcase
    end

    // Events set after clear so a coincident set wins
    s_d.status = s_d.status | evt;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  // State register with asynchronous reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q          <= '0;
      s_q.thr      <= {6{STM_THR_RST}};
      s_q.vgain    <= STM_VG_OLD_RST;
      s_q.meas     <= STM_IDLE;
      s_q.dump_idx <= 4'(STM_DUMP_WORDS);
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state record
  assign wb_ack_out                  = s_q.ack;
  assign wb_dat_out                  = s_q.rdata;
  assign torque_over_flag_out        = s_q.flags[STM_TQ_OVER_BIT];
  assign torque_under_flag_out       = s_q.flags[STM_TQ_UNDER_BIT];
  assign velocity_err_over_flag_out  = s_q.flags[STM_VE_OVER_BIT];
  assign velocity_err_under_flag_out = s_q.flags[STM_VE_UNDER_BIT];
  assign velocity_over_flag_out      = s_q.flags[STM_V_OVER_BIT];
  assign velocity_under_flag_out     = s_q.flags[STM_V_UNDER_BIT];
  assign velocity_prop_gain_out      = s_q.vgain;
  assign irq_out                     = s_q.irq;

endmodule

/* File: stm_monitor_chk.sv */
`timescale 1ns/100ps
module stm_monitor_chk
  import stm_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic        wb_ack_out,
  input wire logic        sample_strobe_in,
  input wire logic        torque_over_flag_out,
  input wire logic        torque_under_flag_out,
  input wire logic        velocity_err_over_flag_out,
  input wire logic        velocity_err_under_flag_out,
  input wire logic        velocity_over_flag_out,
  input wire logic        velocity_under_flag_out,
  input wire logic [15:0] velocity_prop_gain_out
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Bus answers exactly one cycle after a request and only then
  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack stayed high a second cycle");
  ack_answers_a: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered after one cycle");
  ack_cause_a: assert property (
    $rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without a request");
  // Flags move only on the edge after a servo sample
  tq_flags_hold_a: assert property (!$past(sample_strobe_in) |->
    $stable(torque_over_flag_out) && $stable(torque_under_flag_out))
    else $error("torque flag changed without a sample");
  ve_flags_hold_a: assert property (!sample_strobe_in |=>
    $stable({velocity_err_over_flag_out, velocity_err_under_flag_out}))
    else $error("velocity error flag changed without a sample");
  v_flags_hold_a: assert property (!sample_strobe_in ##1 1'b1 |->
    $stable(velocity_over_flag_out) && $stable(velocity_under_flag_out))
    else $error("velocity flag changed without a sample");
  // Gain keeps its range, resets to the older default, moves on writes
  gain_range_a: assert property (velocity_prop_gain_out >= STM_VG_MIN
    && velocity_prop_gain_out <= STM_VG_MAX)
    else $error("gain outside its range");
  gain_reset_a: assert property ($rose(rst_b_in) |->
    velocity_prop_gain_out == STM_VG_OLD_RST)
    else $error("gain not at its default after reset");
  gain_by_write_a: assert property ($changed(velocity_prop_gain_out) |->
    wb_ack_out && $past(wb_we_in))
    else $error("gain changed without a bus write");
endmodule

bind stm_monitor stm_monitor_chk stm_monitor_chk_i (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_ack_out(wb_ack_out),
  .sample_strobe_in(sample_strobe_in),
  .torque_over_flag_out(torque_over_flag_out),
  .torque_under_flag_out(torque_under_flag_out),
  .velocity_err_over_flag_out(velocity_err_over_flag_out),
  .velocity_err_under_flag_out(velocity_err_under_flag_out),
  .velocity_over_flag_out(velocity_over_flag_out),
  .velocity_under_flag_out(velocity_under_flag_out),
  .velocity_prop_gain_out(velocity_prop_gain_out));

/* File: stm_host_model.sv */
`timescale 1ns/100ps
module stm_host_model (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic      [7:0]  adr_out,
  output logic      [3:0]  sel_out,
  output logic      [31:0] dat_out
);
  // Bus idle from time zero
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out  = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'h0;
    dat_out = 32'h0;
  end

  // One classic cycle; the wait is bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic ok);
    int n;
    ok = 1'b0;
    r  = 32'h0;
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out  <= w;
    adr_out <= a;
    sel_out <= 4'hf;
    dat_out <= d;
    for (n = 0; n < 20 && ok !== 1'b1; n++) begin
      @(posedge clk_in);
      if (ack_in === 1'b1) begin
        ok = 1'b1;
        r  = dat_in;
      end
    end
    // Released lines show garbage, not the last value
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out  <= 1'b0;
    sel_out <= 4'h0;
    adr_out <= ~a;
    dat_out <= ~d;
  endtask
endmodule

/* File: stm_monitor_tb_top.sv */
`timescale 1ns/100ps
module stm_monitor_tb_top
  import stm_pkg::*;
;
  logic        clk, rst_b, cyc, stb, we, ack, strb, mst, mdn, irq;
  logic [7:0]  adr;        // Bus address
  logic [3:0]  sel;        // Byte enables
  logic [31:0] wdat, rdat; // Bus data both ways
  logic [31:0] rdv;        // Last read value
  stm_sample_t smp;        // Servo sample under test
  logic [5:0]  flg;        // Flags in status bit order
  logic [15:0] gain, g;    // Gain seen and expected
  logic [15:0] thr [6];    // Expected thresholds
  logic [23:0] dv [9];     // Dumped values kept for restore
  logic [15:0] gv [6] = '{16'h0032, 16'h0096, 16'h0009, 16'h639d,
                          16'h639c, 16'h000a};
  int          error_cnt, checked, seed;

  stm_monitor #(.TICK_CYC(4)) stm_monitor_i (
    .sys_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .sample_in(smp),
    .sample_strobe_in(strb), .move_start_in(mst), .move_done_in(mdn),
    .torque_over_flag_out(flg[0]), .torque_under_flag_out(flg[1]),
    .velocity_err_over_flag_out(flg[2]),
    .velocity_err_under_flag_out(flg[3]),
    .velocity_over_flag_out(flg[4]), .velocity_under_flag_out(flg[5]),
    .velocity_prop_gain_out(gain), .irq_out(irq));
  stm_host_model host_i (.clk_in(clk), .ack_in(ack), .dat_in(rdat),
    .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
    .sel_out(sel), .dat_out(wdat));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus access; a lost answer ends the run at once
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic ok;
    host_i.xfer(w, a, d, rdv, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e, m);
    bus(1'b0, a, 32'h0);
    chk(nm, rdv & m, e & m);
  endtask
  // Expected outputs worked out from the thresholds
  function automatic logic [15:0] mag(input logic [15:0] v);
    if (v == 16'h8000) return 16'h7fff;
    return v[15] ? -v : v;
  endfunction
  function automatic logic [5:0] fx(input stm_sample_t s);
    fx[0] = $signed(s.torque) >= $signed({1'b0, thr[0]});
    fx[1] = $signed(s.torque) <= $signed({1'b0, thr[1]});
    fx[2] = mag(s.verr) >= thr[2];
    fx[3] = mag(s.verr) <= thr[3];
    fx[4] = mag(s.vel) >= thr[4];
    fx[5] = mag(s.vel) <= thr[5];
  endfunction
  function automatic logic [15:0] rnd();
    return 16'($random(seed) % 10001);
  endfunction
  function automatic logic [15:0] ex(input int i);
    if (i < 6) return thr[i];
    if (i == 6) return g;
    return (i == 7) ? 16'h0055 : 16'h0000;
  endfunction
  function automatic logic [7:0] off(input int i);
    return STM_TQ_OVER_OFS + 8'(4 * i);
  endfunction
  task automatic send(input stm_sample_t s);
    @(posedge clk);
    smp  <= s;
    strb <= 1'b1;
    @(posedge clk);
    strb <= 1'b0;
    @(posedge clk);
    #1 chk("flags", {26'h0, flg}, {26'h0, fx(s)});
  endtask
  // Move of n ticks plus half a tick, so the count is n either way
  task automatic move(input int n);
    @(posedge clk);
    mst <= 1'b1;
    @(posedge clk);
    mst <= 1'b0;
    repeat (n * 4 + 1) @(posedge clk);
    mdn <= 1'b1;
    @(posedge clk);
    mdn <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk);
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
  endtask

  initial begin
    stm_sample_t s;
    int i;
    error_cnt = 0; checked = 0; seed = 60468; g = STM_VG_OLD_RST;
    rst_b = 1'b0; smp = '0; strb = 1'b0; mst = 1'b0; mdn = 1'b0;
    for (i = 0; i < 6; i++) thr[i] = STM_THR_RST;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    chk("gain_out", {16'h0, gain}, {16'h0, g});
    for (i = 0; i < 8; i++)
      rc("rst", off(i), {16'h0, i == 6 ? g : 16'h0}, '1);
    bus(1'b1, off(0), 32'h2711);
    rc("thr_clamp", off(0), {16'h0, STM_TQ_MAX}, '1);
    for (i = 0; i < 6; i++) begin
      thr[i] = 16'($unsigned($random(seed)) % 10001);
      bus(1'b1, off(i), {16'h0, thr[i]});
    end
    // Corner samples at the thresholds, the most negative value, random
    for (i = 0; i < 40; i++) begin
      s = {rnd(), rnd(), rnd(), rnd()};
      case (i)
        0: s = {thr[0], thr[4], 16'h0, thr[2]};
        1: s = {thr[1], thr[5], 16'h0, thr[3]};
        2: s = {16'h8000, 16'h8000, 16'h8000, 16'h8000};
        3: s = {-thr[0], -thr[4], 16'h0, -thr[3]};
        default: ;
      endcase
      send(s);
    end
    rc("torque", STM_TORQUE_OFS, {16'h0, s.torque}, 32'hffff);
    rc("vel", STM_VEL_OFS, {16'h0, s.vel}, 32'hffff);
    rc("vcmd", STM_VCMD_OFS, {16'h0, s.vcmd}, 32'hffff);
    rc("verr", STM_VERR_OFS, {16'h0, s.verr}, 32'hffff);
    rc("flag_reg", STM_FLAGS_OFS, {26'h0, fx(s)}, 32'h3f);
    // Move done raises the interrupt; mask and clear take it down
    bus(1'b1, STM_STATUS_OFS, 32'h7f);
    rc("status", STM_STATUS_OFS, 32'h0, 32'h7f);
    bus(1'b1, STM_IRQ_MASK_OFS, 32'h40);
    move(7);
    rc("settle", STM_SETTLE_OFS, 32'h7, '1);
    rc("index", STM_INDEX_OFS, 32'h7, '1);
    irq_is(1'b1);
    bus(1'b1, STM_IRQ_MASK_OFS, 32'h0);
    irq_is(1'b0);
    bus(1'b1, STM_IRQ_MASK_OFS, 32'h40);
    irq_is(1'b1);
    bus(1'b1, STM_STATUS_OFS, 32'h40);
    irq_is(1'b0);
    move(3);
    rc("settle2", STM_SETTLE_OFS, 32'h3, '1);
    rc("index2", STM_INDEX_OFS, 32'h3, '1);
    // Gain writes: same value, change, both bounds and just beyond
    for (i = 0; i < 6; i++) begin
      bus(1'b1, STM_SGAIN_OFS, 32'h55);
      bus(1'b1, STM_VGAIN_OFS, {16'h0, gv[i]});
      s.vcmd = (gv[i] >= STM_VG_MIN && gv[i] <= STM_VG_MAX) ? gv[i] : g;
      rc("sgain", STM_SGAIN_OFS, s.vcmd != g ? 32'h0 : 32'h55, '1);
      g = s.vcmd;
      rc("vgain", STM_VGAIN_OFS, {16'h0, g}, '1);
      chk("gain_out", {16'h0, gain}, {16'h0, g});
    end
    // Dump, scramble, write the dump back and read the eight registers again
    bus(1'b1, STM_SGAIN_OFS, 32'h55);
    bus(1'b1, STM_CTRL_OFS, 32'h2);
    for (i = 0; i < 10; i++) begin
      rc("dump", STM_DUMP_OFS, {4'(i), 12'h0, ex(i)}, '1);
      if (i < 9) dv[i] = rdv[23:0];
    end
    for (i = 0; i < 8; i++) bus(1'b1, off(i), 32'h0100);
    for (i = 0; i < 8; i++) bus(1'b1, off(i), {8'h0, dv[i]});
    bus(1'b1, STM_CTRL_OFS, {8'h0, dv[8]});
    for (i = 0; i < 8; i++) rc("restore", off(i), {16'h0, ex(i)}, '1);
    bus(1'b1, 8'h4c, 32'hffffffff);
    rc("unmapped", 8'h4c, 32'h0, '1);
    // Later hardware version bit is kept and read back
    bus(1'b1, STM_CTRL_OFS, 32'h1);
    rc("newhw", STM_CTRL_OFS, 32'h1, '1);
    print_verdict();
  end
endmodule
